// file: hdl/flash_security.v
// Flash security lock state, backdoor key unlock and debug gating
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "flash_sec_consts.vh"
module flash_security (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [5:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Bus master identity
    input  wire        bdm_access_i,
    input  wire        secure_code_i,
    // Nonvolatile contents
    input  wire [7:0]  nonvolatile_option_byte_i,
    input  wire [63:0] stored_key_i,
    input  wire        blank_check_done_i,
    input  wire        blank_check_erased_i,
    // Debug
    input  wire        background_debug_pin_i,
    input  wire        debug_enable_req_i,
    output reg         debug_enabled_o,
    output reg         active_background_o,
    // Status and flash command path
    output wire        secure_o,
    output wire [7:0]  block_protect_o,
    output wire        flash_cmd_write_o,
    output reg  [7:0]  flash_cmd_data_o,
    output reg  [5:0]  flash_cmd_adr_o
);
    wire [7:0] option_shadow;
    wire       loaded;
    reg  [1:0] lock_state_bits;
    reg  [7:0] block_protect_register;
    reg        compare_access_mode_bit;
    reg        pin_s1;
    reg        pin_s2;
    reg        pin_s3;
    reg        strap_done;
    reg        cmd_pulse;
    wire       key_match;
    wire [3:0] key_count;
    wire       acc;
    wire       wr;
    wire       key_hit;
    wire       key_wr;
    wire       permit;
    wire       cfg_wr;

    assign acc    = cyc_i && stb_i && !ack_o;
    // Writes land at the edge where the master sees ack high
    assign wr     = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    assign key_hit = (adr_i >= `ADR_KEY_BASE) && (adr_i <= `ADR_KEY_LAST);
    assign permit = option_shadow[`OPT_BACKDOOR_PERMIT_BIT_BIT];
    assign cfg_wr = wr && adr_i == `ADR_CONFIG && !bdm_access_i && secure_code_i;
    assign key_wr = wr && key_hit && compare_access_mode_bit && permit
                    && secure_code_i && !bdm_access_i;
    assign secure_o = (lock_state_bits != `SEC_UNLOCKED);
    assign block_protect_o = block_protect_register;
    assign flash_cmd_write_o = cmd_pulse;

    option_loader u_loader (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .nv_option_i            (nonvolatile_option_byte_i),
        .option_shadow_register_o (option_shadow),
        .loaded_o               (loaded)
    );

    key_compare u_key (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .clear_i      (cfg_wr && dat_i[`CFG_COMPARE_ACCESS_MODE_BIT_BIT] && !compare_access_mode_bit),
        .wr_i         (key_wr),
        .idx_i        (adr_i[4:2]),
        .data_i       (dat_i[7:0]),
        .stored_key_i (stored_key_i),
        .match_o      (key_match),
        .count_o      (key_count)
    );

    // Bus answer, registered after one wait state
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= acc;
            dat_o <= 32'h00000000;
            if (acc && !we_i) begin
                case (adr_i)
                    `ADR_CONFIG:  dat_o <= {26'h0, compare_access_mode_bit, 5'h00};
                    `ADR_PROTECT: dat_o <= {24'h0, block_protect_register};
                    `ADR_OPTION:  dat_o <= {24'h0, option_shadow[7:2], lock_state_bits};
                    `ADR_STATUS:  dat_o <= {27'h0, key_count, secure_o};
                    default:      dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Compare mode and lock state
    always @(posedge clk_i) begin
        if (rst_i) begin
            compare_access_mode_bit <= 1'b0;
            lock_state_bits         <= `SEC_ERASED;
        end else begin
            if (!loaded) begin
                lock_state_bits <= {nonvolatile_option_byte_i[`OPT_SEC_HI_BIT],
                                    nonvolatile_option_byte_i[`OPT_SEC_LO_BIT]};
            end else if (blank_check_done_i && blank_check_erased_i) begin
                lock_state_bits <= `SEC_UNLOCKED;
            end else if (cfg_wr && !dat_i[`CFG_COMPARE_ACCESS_MODE_BIT_BIT] && compare_access_mode_bit
                         && key_match && permit) begin
                lock_state_bits <= `SEC_UNLOCKED;
            end
            if (cfg_wr) begin
                compare_access_mode_bit <= dat_i[`CFG_COMPARE_ACCESS_MODE_BIT_BIT] && permit;
            end
        end
    end

    // Block protection written only from the background interface
    always @(posedge clk_i) begin
        if (rst_i) begin
            block_protect_register <= `PROTECT_RESET;
        end else if (wr && adr_i == `ADR_PROTECT && bdm_access_i) begin
            block_protect_register <= dat_i[7:0];
        end
    end

    // Key location writes strobe the flash command path only outside compare mode; data and address latch on every key write
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_pulse        <= 1'b0;
            flash_cmd_data_o <= 8'h00;
            flash_cmd_adr_o  <= 6'h00;
        end else begin
            cmd_pulse <= wr && key_hit && !compare_access_mode_bit;
            if (wr && key_hit) begin
                flash_cmd_data_o <= dat_i[7:0];
                flash_cmd_adr_o  <= adr_i;
            end
        end
    end

    // Background pin synchroniser and reset strap
    always @(posedge clk_i) begin
        pin_s1 <= background_debug_pin_i;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            strap_done          <= 1'b0;
            active_background_o <= 1'b0;
            debug_enabled_o     <= 1'b0;
        end else begin
            if (!strap_done && pin_s2 == pin_s3) begin
                strap_done          <= 1'b1;
                active_background_o <= !pin_s3;
            end
            if (debug_enable_req_i && !secure_o && loaded) begin
                debug_enabled_o <= 1'b1;
            end else if (secure_o) begin
                debug_enabled_o <= 1'b0;
            end
        end
    end
endmodule // flash_security

// file: hdl/flash_sec_consts.vh
// Offsets, field positions, reset values and constants of the flash security block
`ifndef FLASH_SEC_CONSTS_VH
`define FLASH_SEC_CONSTS_VH
`define ADR_CONFIG       6'h00
`define ADR_PROTECT      6'h04
`define ADR_OPTION       6'h08
`define ADR_STATUS       6'h0C
`define ADR_KEY_BASE     6'h20
`define ADR_KEY_LAST     6'h3C
`define CFG_COMPARE_ACCESS_MODE_BIT_BIT   5
`define OPT_BACKDOOR_PERMIT_BIT_BIT    7
`define OPT_SEC_HI_BIT   1
`define OPT_SEC_LO_BIT   0
`define SEC_UNLOCKED     2'h2
`define SEC_ERASED       2'h3
`define OPTION_RESET     8'hFF
`define PROTECT_RESET    8'hFF
`define KEY_BYTES        8
`define VECTOR_BLOCK_BYTES 768
`endif

// file: hdl/key_compare.v
// Backdoor key comparison: eight ordered key bytes checked against the stored key
`timescale 1ns/10ps
`include "flash_sec_consts.vh"
module key_compare (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Control
    input  wire        clear_i,
    input  wire        wr_i,
    input  wire [2:0]  idx_i,
    input  wire [7:0]  data_i,
    input  wire [63:0] stored_key_i,
    // Result
    output wire        match_o,
    output reg  [3:0]  count_o
);
    reg  [7:0] good;
    reg        order_ok;
    genvar     g;
    generate
        for (g = 0; g < `KEY_BYTES; g = g + 1) begin : gen_byte
            localparam [2:0] SLOT = g;
            always @(posedge clk_i) begin
                if (rst_i || clear_i) begin
                    good[g] <= 1'b0;
                end else if (wr_i && idx_i == SLOT) begin
                    good[g] <= (data_i == stored_key_i[g*8 +: 8]);
                end
            end
        end
    endgenerate
    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count_o  <= 4'h0;
            order_ok <= 1'b1;
        end else if (wr_i) begin
            if ({1'b0, idx_i} != count_o) begin
                order_ok <= 1'b0;
            end
            if (count_o != 4'h8) begin
                count_o <= count_o + 4'h1;
            end
        end
    end
    assign match_o = order_ok && (count_o == 4'h8) && (&good);
endmodule // key_compare

// file: hdl/option_loader.v
// Load of the option shadow register, permit bit included, from the nonvolatile option byte
`timescale 1ns/10ps
`include "flash_sec_consts.vh"
module option_loader (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Nonvolatile source
    input  wire [7:0] nv_option_i,
    // Shadow
    output reg  [7:0] option_shadow_register_o,
    output reg        loaded_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            option_shadow_register_o <= `OPTION_RESET;
            loaded_o                 <= 1'b0;
        end else if (!loaded_o) begin
            option_shadow_register_o <= nv_option_i;
            loaded_o                 <= 1'b1;
        end
    end
endmodule // option_loader

// file: tb/flash_sec_asserts.sv
// Port checks of the flash security block
`timescale 1ns/10ps
module flash_sec_asserts (
    // Clock and reset
    input wire       clk_i,
    input wire       rst_i,
    // Bus
    input wire       cyc_i,
    input wire       stb_i,
    input wire       we_i,
    input wire [5:0] adr_i,
    input wire       bdm_access_i,
    input wire       ack_o,
    // Security
    input wire [7:0] nonvolatile_option_byte_i,
    input wire       blank_check_done_i,
    input wire       blank_check_erased_i,
    input wire       background_debug_pin_i,
    input wire       secure_o,
    input wire       debug_enabled_o,
    input wire       active_background_o,
    input wire [7:0] block_protect_o
);
    reg  [3:0] since;
    wire       unl = ack_o & we_i & (adr_i == 6'h00) | blank_check_done_i & blank_check_erased_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always @(posedge clk_i) since <= rst_i ? 4'h0 : since + {3'h0, since != 4'hF};
    AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("long ack");
    AST_DEBUG_GATE: assert property (secure_o |-> !debug_enabled_o)
        else $error("debug while secure");
    AST_LOCK_LOAD: assert property ($fell(rst_i) |-> ##2
        secure_o == (nonvolatile_option_byte_i[1:0] != 2'h2)) else $error("lock load");
    AST_UNLOCK_CAUSE: assert property ($fell(secure_o) |->
        $past(unl) || $past(unl, 2) || $past(rst_i, 3)) else $error("stray unlock");
    AST_RELOCK: assert property ($rose(secure_o) |-> $past(rst_i))
        else $error("stray relock");
    AST_PROTECT: assert property ($changed(block_protect_o) |-> $past(rst_i) ||
        $past(ack_o && we_i && bdm_access_i && adr_i == 6'h04)) else $error("protect");
    AST_BACKGROUND: assert property ($rose(active_background_o) |->
        !background_debug_pin_i && since < 4'hC) else $error("background entry");
endmodule // flash_sec_asserts
bind flash_security flash_sec_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .bdm_access_i(bdm_access_i), .ack_o(ack_o),
    .nonvolatile_option_byte_i(nonvolatile_option_byte_i),
    .blank_check_done_i(blank_check_done_i), .blank_check_erased_i(blank_check_erased_i),
    .background_debug_pin_i(background_debug_pin_i), .secure_o(secure_o),
    .debug_enabled_o(debug_enabled_o), .active_background_o(active_background_o),
    .block_protect_o(block_protect_o));

// file: tb/nv_flash_model.sv
// Nonvolatile array model: option byte, backdoor key and blank check
`timescale 1ns/10ps
module nv_flash_model #(parameter [63:0] KEY = 64'h0F1E2D3C4B5A6978) (
    // Clock
    input  wire        clk_i,
    // Host commands
    input  wire        prog_i,
    input  wire [7:0]  opt_i,
    input  wire        erase_i,
    input  wire        check_i,
    input  wire [3:0]  delay_i,
    // Array state
    output reg  [7:0]  option_o = 8'hFF,
    output wire [63:0] key_o,
    output reg         done_o = 1'b0,
    output reg         erased_o = 1'b1
);
    reg [4:0] cnt = 5'h0;
    assign key_o = erased_o ? 64'hFFFFFFFFFFFFFFFF : KEY;
    always @(posedge clk_i) begin
        done_o <= (cnt == 5'h01);
        cnt <= check_i ? {1'b0, delay_i} + 5'h01 : cnt - {4'h0, cnt != 5'h00};
        if (erase_i) begin
            option_o <= 8'hFF;
            erased_o <= 1'b1;
        end else if (prog_i) begin
            option_o <= opt_i;
            erased_o <= 1'b0;
        end
    end
endmodule // nv_flash_model

// file: tb/tb_flash_security.sv
// Self-checking testbench of the flash security block
`timescale 1ns/10ps
`include "flash_sec_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_flash_security;
    localparam [63:0] KEY = 64'h0F1E2D3C4B5A6978;
    reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, bdm = 0, scode = 1;
    reg         pin = 1, dreq = 0, prog = 0, erase = 0, check = 0, as_bdm = 0;
    reg  [3:0]  dly = 4'h0;
    reg  [5:0]  adr_i = 6'h00;
    reg  [7:0]  opt = 8'h83, r;
    reg  [31:0] dat_i = 32'h0;
    wire [31:0] dat_o;
    wire [63:0] key;
    wire [7:0]  nvo, prot, cdat;
    wire [5:0]  cadr;
    wire        ack_o, done, ers, sec, dbg, bg, cmd;
    integer     errors = 0, compares = 0, cmds = 0, i;
    nv_flash_model #(.KEY(KEY)) u_nv (.clk_i(clk_i), .prog_i(prog), .opt_i(opt),
        .erase_i(erase), .check_i(check), .delay_i(dly), .option_o(nvo), .key_o(key),
        .done_o(done), .erased_o(ers));
    flash_security DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .bdm_access_i(bdm), .secure_code_i(scode), .nonvolatile_option_byte_i(nvo),
        .stored_key_i(key), .blank_check_done_i(done), .blank_check_erased_i(ers),
        .background_debug_pin_i(pin), .debug_enable_req_i(dreq), .debug_enabled_o(dbg),
        .active_background_o(bg), .secure_o(sec), .block_protect_o(prot),
        .flash_cmd_write_o(cmd), .flash_cmd_data_o(cdat), .flash_cmd_adr_o(cadr));
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (cmd === 1'b1) cmds++;
    initial begin
        #100000;
        errors++;
        end_of_test;
    end
    task end_of_test;
        begin
            $display("compares %0d errors %0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task xfer(input w, input [5:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
            {bdm, scode} <= {as_bdm, !as_bdm};
            do @(posedge clk_i); while (ack_o !== 1'b1);
            r = dat_o[7:0];
            {cyc_i, stb_i} <= 2'b00;
            @(negedge clk_i);
        end
    endtask
    task keys(input [63:0] k);
        integer j;
        begin
            xfer(1, `ADR_CONFIG, 8'h20);
            for (j = 0; j < `KEY_BYTES; j++)
                xfer(1, `ADR_KEY_BASE + 6'(4 * j), k[8 * j +: 8]);
            xfer(1, `ADR_CONFIG, 8'h00);
            repeat (3) @(negedge clk_i);
        end
    endtask
    task do_reset(input [7:0] o, input p, input pg);
        begin
            @(posedge clk_i);
            {opt, prog, pin, rst_i} <= {o, pg, p, 1'b1};
            repeat (5) @(posedge clk_i);
            {prog, rst_i} <= 2'b00;
            repeat (10) @(posedge clk_i);
        end
    endtask
    task blank(input e, input [3:0] d);
        begin
            @(posedge clk_i);
            {erase, dly} <= {e, d};
            @(posedge clk_i);
            {erase, check} <= 2'b01;
            @(posedge clk_i);
            check <= 1'b0;
            do @(posedge clk_i); while (done !== 1'b1);
            repeat (3) @(negedge clk_i);
        end
    endtask
    initial begin
        for (i = 0; i < 4; i++) begin
            do_reset(8'h80 | i[7:0], 1'b1, 1'b1);
            `CHK(sec, i != 2)
            xfer(0, `ADR_OPTION, 8'h00);
            `CHK(r[1:0], i[1:0])
        end
        `CHK(prot, `PROTECT_RESET)
        xfer(0, 6'h14, 8'h00);
        `CHK(r, 8'h00)
        xfer(1, `ADR_PROTECT, 8'h00);
        `CHK(prot, 8'hFF)
        as_bdm = 1;
        xfer(1, `ADR_PROTECT, 8'h00);
        `CHK(prot, 8'h00)
        keys(KEY);
        `CHK(sec, 1'b1)
        as_bdm = 0;
        $display("lock and protect done");
        do_reset(8'h03, 1'b0, 1'b1);
        `CHK(bg, 1'b1)
        cmds = 0;
        keys(KEY);
        `CHK(sec, 1'b1)
        `CHK(cmds, 8)
        `CHK({cadr, cdat}, {6'h3C, KEY[63:56]})
        do_reset(8'h83, 1'b1, 1'b1);
        `CHK(bg, 1'b0)
        dreq <= 1'b1;
        keys(KEY ^ 64'h1);
        `CHK(sec, 1'b1)
        `CHK(dbg, 1'b0)
        cmds = 0;
        keys(KEY);
        `CHK(sec, 1'b0)
        `CHK(cmds, 0)
        `CHK(dbg, 1'b1)
        xfer(0, `ADR_STATUS, 8'h00);
        `CHK(r[0], 1'b0)
        `CHK(r[4:1], 4'h8)
        do_reset(8'h83, 1'b1, 1'b0);
        `CHK(sec, 1'b1)
        $display("backdoor key done");
        as_bdm = 1;
        xfer(1, `ADR_PROTECT, 8'h00);
        blank(1'b0, 4'h0);
        `CHK(sec, 1'b1)
        blank(1'b1, 4'h9);
        `CHK(sec, 1'b0)
        do_reset(8'h00, 1'b1, 1'b0);
        `CHK(sec, 1'b1)
        do_reset(8'hFE, 1'b1, 1'b1);
        `CHK(sec, 1'b0)
        $display("blank check done");
        end_of_test;
    end
endmodule // tb_flash_security
